/* osq_map.vh */
`ifndef OSQ_MAP_VH
`define OSQ_MAP_VH
// Register offsets
`define OSQ_ADDR_MODE      8'h10
`define OSQ_ADDR_RATE      8'h12
`define OSQ_ADDR_AVG       8'h15
`define OSQ_ADDR_PULSE_A   8'h31
`define OSQ_ADDR_PULSE_B   8'h36
`define OSQ_ADDR_EXT_TRIG  8'h38
`define OSQ_ADDR_SLOW_OSC  8'h4B
`define OSQ_ADDR_PIN_CFG   8'h4F
// Reset values
`define OSQ_RST_WORD       16'h0000
`define OSQ_RST_RATE       16'h0020
`define OSQ_RST_PULSE      16'h0100
// Mode field and codes
`define OSQ_MODE_LSB       0
`define OSQ_MODE_MSB       1
`define OSQ_MODE_STANDBY   2'h0
`define OSQ_MODE_PROGRAM   2'h1
`define OSQ_MODE_NORMAL    2'h2
// Field positions
`define OSQ_EXT_TRIG_EN    14
`define OSQ_SLOW_EN        7
`define OSQ_SLOW_BYP       8
`define OSQ_INT_BUF_EN     1
`define OSQ_TRIG_SEL_LSB   2
`define OSQ_TRIG_SEL_MSB   3
`define OSQ_PDS_BUF_EN     5
`define OSQ_TRIG_SEL_NONE  2'h0
`define OSQ_TRIG_SEL_INT   2'h1
`define OSQ_TRIG_SEL_PDS   2'h2
`define OSQ_PULSE_LSB      8
`define OSQ_PULSE_MSB      15
`define OSQ_AVG_A_LSB      4
`define OSQ_AVG_A_MSB      6
`define OSQ_AVG_B_LSB      8
`define OSQ_AVG_B_MSB      10
`define OSQ_AVG_FIFO_SLOT  12
// Slow clock timing and 20-bit clip limit
`define OSQ_SLOW_PERIOD_NS 31250
`define OSQ_CLK_PERIOD_NS  10
`define OSQ_CLIP20_MAX     20'hFFFFF
`endif

/* osq_pin_edge.v */
module osq_pin_edge (
  input  wire i_clk,
  input  wire i_srst,
  input  wire i_pin,
  output reg  o_level,
  output reg  o_rise
);
  reg meta_ff;
  reg sync_ff;
  ////////////////////////////////////////////////////////////////////////////
  // Two-flop synchroniser, then edge detect on the settled level only
  always @(posedge i_clk) begin
    if (i_srst) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      o_level <= 1'b0;
      o_rise  <= 1'b0;
    end else begin
      meta_ff <= i_pin;
      sync_ff <= meta_ff;
      o_level <= sync_ff;
      o_rise  <= sync_ff & ~o_level;
    end
  end
endmodule // osq_pin_edge

/* osq_slot_accum.v */
`include "osq_map.vh"
module osq_slot_accum #(
  parameter CONV_W = 14,
  parameter SUM_W  = 20,
  parameter ACC_W  = 27
) (
  input  wire        i_clk,
  input  wire        i_srst,
  input  wire        i_clear,
  input  wire        i_conv_valid,
  input  wire [13:0] i_conv,
  input  wire        i_end_sample,
  input  wire [2:0]  i_avg_log2,
  output reg  [31:0] o_sum,
  output reg  [31:0] o_div,
  output reg         o_new
);
  reg  [SUM_W-1:0] pulse_sum_ff;
  reg  [ACC_W-1:0] acc_ff;
  reg  [7:0]       cnt_ff;
  wire [SUM_W:0]   pulse_add  = {1'b0, pulse_sum_ff} + {{(SUM_W+1-CONV_W){1'b0}}, i_conv};
  wire [SUM_W-1:0] pulse_clip = pulse_add[SUM_W] ? `OSQ_CLIP20_MAX : pulse_add[SUM_W-1:0]; // [R17]
  // The closing conversion arrives with the end strobe, so it is folded in here
  wire [SUM_W-1:0] sample_sum = i_conv_valid ? pulse_clip : pulse_sum_ff;
  wire [ACC_W-1:0] acc_next   = acc_ff + {{(ACC_W-SUM_W){1'b0}}, sample_sum};
  wire [7:0]       last_cnt  = (8'h01 << i_avg_log2) - 8'h01;
  ////////////////////////////////////////////////////////////////////////////
  // Pulse sum saturates at 20 bits; the period result is the clipped value
  always @(posedge i_clk) begin
    if (i_srst || i_clear) begin
      pulse_sum_ff <= {SUM_W{1'b0}};
    end else if (i_end_sample) begin
      pulse_sum_ff <= {SUM_W{1'b0}};
    end else if (i_conv_valid) begin
      pulse_sum_ff <= pulse_clip; // [R17]
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // N-sample sum; outputs change only every Nth sample, FIFO copy divided by N
  always @(posedge i_clk) begin
    if (i_srst || i_clear) begin
      acc_ff <= {ACC_W{1'b0}};
      cnt_ff <= 8'h00;
      o_sum  <= 32'h00000000;
      o_div  <= 32'h00000000;
      o_new  <= 1'b0;
    end else begin
      o_new <= 1'b0;
      if (i_end_sample) begin
        if (cnt_ff == last_cnt) begin // [R18]
          acc_ff <= {ACC_W{1'b0}};
          cnt_ff <= 8'h00;
          o_sum  <= {{(32-ACC_W){1'b0}}, acc_next}; // [R19]
          o_div  <= {{(32-ACC_W){1'b0}}, acc_next >> i_avg_log2}; // [R20]
          o_new  <= 1'b1;
        end else begin
          acc_ff <= acc_next; // [R19]
          cnt_ff <= cnt_ff + 8'h01;
        end
      end
    end
  end
endmodule // osq_slot_accum

/* osq_sequencer.v */
// Contract
// [R1] Two-bit field selects external trigger pin
// [R2] Rising edge on selected pin starts sample
// [R3] Wait one-two slow cycles, then start
// [R4] Host enables pin input buffer first
// [R5] Host programs trigger via program mode
// [R6] Host keeps trigger below max rate
// [R7] Sync pin may supply external slow clock
// [R8] Host never floats sync pin
// [R9] Enable plus bypass selects external slow clock; code also needs the sync pin buffer enable set
// [R10] Host selects external clock before programming
// [R11] Decode standby, program, normal mode codes
// [R12] Standby collects nothing, keeps registers
// [R13] Mode field resets to standby
// [R14] Host passes through program mode
// [R15] Program mode keeps circuits powered
// [R16] Sample sums 1 to 255 pulses
// [R17] Add 14-bit conversions, clip at 20
// [R18] Average power-of-two samples, update every Nth
// [R19] 27-bit sum held in 32-bit registers
// [R20] FIFO receives sum divided by N
// [R21] Unequal factors: only one slot feeds FIFO
// [R22] Host keeps pulse count eight or less
// [R23] Slot A then slot B each period
// [R24] Slow clock paces sampling and sequencing
// [R25] Trigger synchronised into slow clock domain
// [R26] Triggers ignored outside normal mode
`include "osq_map.vh"
module osq_sequencer #(
  parameter SLOW_DIV = `OSQ_SLOW_PERIOD_NS / `OSQ_CLK_PERIOD_NS
) (
  input  wire        i_clk,
  input  wire        i_srst,
  input  wire        i_reg_wr,
  input  wire        i_reg_rd,
  input  wire [7:0]  i_reg_addr,
  input  wire [15:0] i_reg_wdata,
  output reg  [15:0] o_reg_rdata,
  input  wire        i_int_pin,
  input  wire        i_photodiode_sync_pin,
  input  wire        i_conv_valid,
  input  wire [13:0] i_conv_data,
  output reg         o_pulse_req,
  output reg         o_slot_b,
  output reg         o_power_hold,
  output reg         o_sampling,
  output reg  [31:0] o_slota_data,
  output reg  [31:0] o_slotb_data,
  output reg         o_data_new,
  output reg         o_fifo_wr,
  output reg  [31:0] o_fifo_data
);
  localparam [31:0] DIV_LAST_W = SLOW_DIV - 1;
  localparam [15:0] DIV_LAST   = DIV_LAST_W[15:0];
  localparam [2:0]  ST_IDLE  = 3'h1;
  localparam [2:0]  ST_SLOTA = 3'h2;
  localparam [2:0]  ST_SLOTB = 3'h4;

  reg  [15:0] mode_ff, rate_ff, avg_ff, pulse_a_ff, pulse_b_ff, ext_ff, osc_ff, pin_ff;
  reg  [15:0] div_ff, timer_ff;
  reg  [2:0]  state_ff, nxt_state;
  reg  [7:0]  pcnt_ff;
  reg         trig_smp_ff, trig_wait_ff, start_ff;
  reg         slow_tick_ff;
  wire        int_lvl, pds_lvl, pds_rise;
  wire [31:0] sum_a, sum_b, div_a, div_b;
  wire        new_a, new_b;
  wire [1:0]  mode     = mode_ff[`OSQ_MODE_MSB:`OSQ_MODE_LSB];
  wire        normal   = (mode == `OSQ_MODE_NORMAL); // [R11]
  wire [1:0]  trig_sel = pin_ff[`OSQ_TRIG_SEL_MSB:`OSQ_TRIG_SEL_LSB];
  wire        ext_clk  = osc_ff[`OSQ_SLOW_EN] & osc_ff[`OSQ_SLOW_BYP] & pin_ff[`OSQ_PDS_BUF_EN];
  wire        ext_trig = ext_ff[`OSQ_EXT_TRIG_EN] & (trig_sel != `OSQ_TRIG_SEL_NONE);
  wire [2:0]  avg_a    = avg_ff[`OSQ_AVG_A_MSB:`OSQ_AVG_A_LSB];
  wire [2:0]  avg_b    = avg_ff[`OSQ_AVG_B_MSB:`OSQ_AVG_B_LSB];
  wire [7:0]  n_pulse  = o_slot_b ? pulse_b_ff[`OSQ_PULSE_MSB:`OSQ_PULSE_LSB]
                                  : pulse_a_ff[`OSQ_PULSE_MSB:`OSQ_PULSE_LSB];
  wire [7:0]  n_eff    = (n_pulse == 8'h00) ? 8'h01 : n_pulse;
  wire        in_slot  = (state_ff != ST_IDLE);
  wire        slot_end = in_slot & i_conv_valid & (pcnt_ff == n_eff - 8'h01);
  reg         trig_lvl;

  ////////////////////////////////////////////////////////////////////////////
  // Pin conditioning; a buffer that is off reads as low
  osq_pin_edge u_int_pin (
    .i_clk   (i_clk),
    .i_srst  (i_srst),
    .i_pin   (i_int_pin & pin_ff[`OSQ_INT_BUF_EN]),
    .o_level (int_lvl),
    .o_rise  ()
  );
  osq_pin_edge u_pds_pin (
    .i_clk   (i_clk),
    .i_srst  (i_srst),
    .i_pin   (i_photodiode_sync_pin & pin_ff[`OSQ_PDS_BUF_EN]),
    .o_level (pds_lvl),
    .o_rise  (pds_rise)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register writes; all fields persist in every mode, standby included
  always @(posedge i_clk) begin
    if (i_srst) begin
      mode_ff    <= `OSQ_RST_WORD; // [R13]
      rate_ff    <= `OSQ_RST_RATE;
      avg_ff     <= `OSQ_RST_WORD;
      pulse_a_ff <= `OSQ_RST_PULSE;
      pulse_b_ff <= `OSQ_RST_PULSE;
      ext_ff     <= `OSQ_RST_WORD;
      osc_ff     <= `OSQ_RST_WORD;
      pin_ff     <= `OSQ_RST_WORD;
    end else if (i_reg_wr) begin
      case (i_reg_addr)
        `OSQ_ADDR_MODE:     mode_ff    <= i_reg_wdata;
        `OSQ_ADDR_RATE:     rate_ff    <= i_reg_wdata;
        `OSQ_ADDR_AVG:      avg_ff     <= i_reg_wdata;
        `OSQ_ADDR_PULSE_A:  pulse_a_ff <= i_reg_wdata; // [R16]
        `OSQ_ADDR_PULSE_B:  pulse_b_ff <= i_reg_wdata;
        `OSQ_ADDR_EXT_TRIG: ext_ff     <= i_reg_wdata;
        `OSQ_ADDR_SLOW_OSC: osc_ff     <= i_reg_wdata;
        `OSQ_ADDR_PIN_CFG:  pin_ff     <= i_reg_wdata;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register reads; unmapped addresses return zero
  always @(posedge i_clk) begin
    if (i_srst) begin
      o_reg_rdata <= `OSQ_RST_WORD;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        `OSQ_ADDR_MODE:     o_reg_rdata <= mode_ff;
        `OSQ_ADDR_RATE:     o_reg_rdata <= rate_ff;
        `OSQ_ADDR_AVG:      o_reg_rdata <= avg_ff;
        `OSQ_ADDR_PULSE_A:  o_reg_rdata <= pulse_a_ff;
        `OSQ_ADDR_PULSE_B:  o_reg_rdata <= pulse_b_ff;
        `OSQ_ADDR_EXT_TRIG: o_reg_rdata <= ext_ff;
        `OSQ_ADDR_SLOW_OSC: o_reg_rdata <= osc_ff;
        `OSQ_ADDR_PIN_CFG:  o_reg_rdata <= pin_ff;
        default:            o_reg_rdata <= `OSQ_RST_WORD;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Slow tick: internal divider or rising edges of the external clock.
  // The divider free-runs so switching sources never stalls the tick.
  always @(posedge i_clk) begin
    if (i_srst) begin
      div_ff       <= 16'h0000;
      slow_tick_ff <= 1'b0;
    end else begin
      div_ff       <= (div_ff == DIV_LAST) ? 16'h0000 : div_ff + 16'h0001;
      slow_tick_ff <= ext_clk ? pds_rise : (div_ff == DIV_LAST); // [R7] [R9] [R24]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trigger source choice
  always @* begin
    case (trig_sel) // [R1]
      `OSQ_TRIG_SEL_INT: trig_lvl = int_lvl;
      `OSQ_TRIG_SEL_PDS: trig_lvl = pds_lvl;
      default:           trig_lvl = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sample start: timer in slow ticks, or external edge sampled on slow ticks.
  // A rise is seen at one tick and acted on at the next, giving 1-2 cycles.
  // The level is followed in every mode, so a pin raised while programming
  // is not mistaken for an edge once sampling begins.
  always @(posedge i_clk) begin
    if (i_srst) begin
      timer_ff     <= 16'h0000;
      trig_smp_ff  <= 1'b0;
      trig_wait_ff <= 1'b0;
      start_ff     <= 1'b0;
    end else begin
      start_ff <= 1'b0;
      if (slow_tick_ff) begin
        trig_smp_ff <= trig_lvl; // [R25]
      end
      if (!normal) begin // [R12] [R26]
        timer_ff     <= 16'h0000;
        trig_wait_ff <= 1'b0;
      end else if (slow_tick_ff) begin
        if (ext_trig) begin
          trig_wait_ff <= trig_lvl & ~trig_smp_ff; // [R2]
          start_ff     <= trig_wait_ff; // [R3]
        end else if (timer_ff + 16'h0001 >= rate_ff) begin
          timer_ff <= 16'h0000;
          start_ff <= 1'b1;
        end else begin
          timer_ff <= timer_ff + 16'h0001;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Slot sequencing: A then B; a start during a busy period is dropped
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (start_ff && normal) begin
          nxt_state = ST_SLOTA; // [R23]
        end
      end
      ST_SLOTA: begin
        if (!normal) begin
          nxt_state = ST_IDLE;
        end else if (slot_end) begin
          nxt_state = ST_SLOTB; // [R23]
        end
      end
      ST_SLOTB: begin
        if (!normal || slot_end) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge i_clk) begin
    if (i_srst) begin
      state_ff     <= ST_IDLE;
      pcnt_ff      <= 8'h00;
      o_pulse_req  <= 1'b0;
      o_slot_b     <= 1'b0;
      o_power_hold <= 1'b0;
      o_sampling   <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      o_power_hold <= (mode == `OSQ_MODE_PROGRAM); // [R15]
      o_sampling   <= (nxt_state != ST_IDLE);
      o_slot_b     <= (nxt_state == ST_SLOTB);
      o_pulse_req  <= 1'b0;
      if (nxt_state != state_ff && nxt_state != ST_IDLE) begin
        pcnt_ff     <= 8'h00;
        o_pulse_req <= 1'b1;
      end else if (in_slot && i_conv_valid && !slot_end) begin
        pcnt_ff     <= pcnt_ff + 8'h01; // [R16]
        o_pulse_req <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-slot datapaths
  osq_slot_accum u_acc_a (
    .i_clk        (i_clk),
    .i_srst       (i_srst),
    .i_clear      (~normal),
    .i_conv_valid (i_conv_valid & (state_ff == ST_SLOTA)),
    .i_conv       (i_conv_data), // [R17]
    .i_end_sample (slot_end & (state_ff == ST_SLOTA)),
    .i_avg_log2   (avg_a),
    .o_sum        (sum_a),
    .o_div        (div_a),
    .o_new        (new_a)
  );
  osq_slot_accum u_acc_b (
    .i_clk        (i_clk),
    .i_srst       (i_srst),
    .i_clear      (~normal),
    .i_conv_valid (i_conv_valid & (state_ff == ST_SLOTB)),
    .i_conv       (i_conv_data),
    .i_end_sample (slot_end & (state_ff == ST_SLOTB)),
    .i_avg_log2   (avg_b),
    .o_sum        (sum_b),
    .o_div        (div_b),
    .o_new        (new_b)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Output registers and FIFO push. A and B never finish in the same cycle,
  // so a single push port suffices. Unequal factors: only the chosen slot.
  always @(posedge i_clk) begin
    if (i_srst) begin
      o_slota_data <= 32'h00000000;
      o_slotb_data <= 32'h00000000;
      o_data_new   <= 1'b0;
      o_fifo_wr    <= 1'b0;
      o_fifo_data  <= 32'h00000000;
    end else begin
      o_data_new <= new_a | new_b;
      o_fifo_wr  <= 1'b0;
      if (new_a) begin
        o_slota_data <= sum_a; // [R19]
      end
      if (new_b) begin
        o_slotb_data <= sum_b;
      end
      if (new_a && (avg_a == avg_b || !avg_ff[`OSQ_AVG_FIFO_SLOT])) begin // [R21]
        o_fifo_wr   <= 1'b1;
        o_fifo_data <= div_a; // [R20]
      end else if (new_b && (avg_a == avg_b || avg_ff[`OSQ_AVG_FIFO_SLOT])) begin // [R21]
        o_fifo_wr   <= 1'b1;
        o_fifo_data <= div_b;
      end
    end
  end
endmodule // osq_sequencer

/* osq_sequencer_props.sv */
module osq_sequencer_props (
  input logic        i_clk,
  input logic        i_srst,
  input logic        i_reg_wr,
  input logic [7:0]  i_reg_addr,
  input logic [15:0] i_reg_wdata,
  input logic        o_pulse_req,
  input logic        o_slot_b,
  input logic        o_power_hold,
  input logic        o_sampling,
  input logic        o_data_new,
  input logic        o_fifo_wr
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  logic [1:0] mode_ff;
  logic       mode_wr;
  // Mode shadow from bus writes, so sample starts can be judged against it
  assign mode_wr = i_reg_wr && (i_reg_addr == 8'h10);
  always_ff @(posedge i_clk) begin
    if (i_srst)
      mode_ff <= 2'h0;
    else if (mode_wr)
      mode_ff <= i_reg_wdata[1:0];
  end
  ////////////////////////////////////////
  chk_reset_idle: assert property ($fell(i_srst) |-> !o_power_hold && !o_sampling && !o_pulse_req)
    else $error("busy after reset");
  chk_program_power: assert property (mode_wr |-> ##2 (o_power_hold == ($past(i_reg_wdata[1:0], 2) == 2'h1)))
    else $error("power hold wrong for mode");
  chk_standby_idle: assert property (mode_wr && (i_reg_wdata[1:0] == 2'h0) |-> ##2 (!o_sampling && !o_fifo_wr) [*8])
    else $error("activity in standby");
  chk_pulse_single: assert property (o_pulse_req |=> !o_pulse_req)
    else $error("pulse request too long");
  chk_pulse_in_sample: assert property (o_pulse_req |-> o_sampling)
    else $error("pulse request outside sample");
  chk_start_slot_a: assert property ($rose(o_sampling) |-> o_pulse_req && !o_slot_b)
    else $error("sample not opened by slot A");
  chk_start_normal: assert property ($rose(o_sampling) |-> (mode_ff == 2'h2) && ($past(mode_ff) == 2'h2))
    else $error("sample started outside normal mode");
  chk_fifo_with_new: assert property (o_fifo_wr |-> o_data_new)
    else $error("fifo push without data update");
endmodule // osq_sequencer_props

/* osq_afe_model.sv */
module osq_afe_model (
  input  logic        i_clk,
  input  logic        i_srst,
  input  logic        i_pulse_req,
  input  logic [3:0]  i_lag,
  input  logic [13:0] i_level,
  output logic        o_conv_valid,
  output logic [13:0] o_conv_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       busy_ff;
  logic [3:0] wait_ff;
  // One conversion per LED pulse after i_lag cycles; data wobbles when idle so stale values never match
  always @(posedge i_clk) begin
    o_conv_valid <= 1'h0;
    o_conv_data <= ~o_conv_data;
    if (i_srst) begin
      busy_ff     <= 1'h0;
      wait_ff     <= 4'h0;
      o_conv_data <= 14'h2AAA;
    end else if (i_pulse_req) begin
      busy_ff <= 1'h1;
      wait_ff <= i_lag;
    end else if (busy_ff && wait_ff != 4'h0) begin
      wait_ff <= wait_ff - 4'h1;
    end else if (busy_ff) begin
      busy_ff <= 1'h0;
      o_conv_valid <= 1'h1;
      o_conv_data <= i_level;
    end
  end
endmodule // osq_afe_model

/* osq_sequencer_test.sv */
module osq_sequencer_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SLOW_DIV = 8;
  logic        i_clk = 1'h0;
  logic        i_srst = 1'h1;
  logic        i_reg_wr = 1'h0;
  logic        i_reg_rd = 1'h0;
  logic [7:0]  i_reg_addr = 8'h00;
  logic [15:0] i_reg_wdata = 16'h0000;
  logic        i_int_pin = 1'h0;
  logic        i_photodiode_sync_pin = 1'h0;
  logic        i_conv_valid;
  logic [13:0] i_conv_data;
  logic [15:0] o_reg_rdata;
  logic        o_pulse_req, o_slot_b, o_power_hold, o_sampling, o_data_new, o_fifo_wr;
  logic [31:0] o_slota_data, o_slotb_data, o_fifo_data;
  logic [3:0]  lag = 4'h0;
  logic [13:0] level = 14'h3FFF;
  int          n_errors = 0;
  int          total_checks = 0;
  // Short slow-clock divider keeps the run small
  osq_sequencer #(.SLOW_DIV(SLOW_DIV)) DUT (.i_clk, .i_srst, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata,
    .o_reg_rdata, .i_int_pin, .i_photodiode_sync_pin, .i_conv_valid, .i_conv_data, .o_pulse_req, .o_slot_b,
    .o_power_hold, .o_sampling, .o_slota_data, .o_slotb_data, .o_data_new, .o_fifo_wr, .o_fifo_data);
  osq_afe_model afe (.i_clk, .i_srst, .i_pulse_req(o_pulse_req), .i_lag(lag), .i_level(level),
    .o_conv_valid(i_conv_valid), .o_conv_data(i_conv_data));
  // Free-running 100 MHz clock
  always #5 i_clk = ~i_clk;
  ////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input logic ok, input string what);
    total_checks++;
    if (ok !== 1'h1) begin
      n_errors++;
      $display("mismatch at %0t: %s", $time, what);
    end
  endtask
  // Bus strobes change at the falling edge and last one cycle
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge i_clk);
    i_reg_wr = 1'h1;
    i_reg_addr = a;
    i_reg_wdata = d;
    @(negedge i_clk);
    i_reg_wr = 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(negedge i_clk);
    i_reg_rd = 1'h1;
    i_reg_addr = a;
    @(negedge i_clk);
    i_reg_rd = 1'h0;
    check(o_reg_rdata === exp, "register read");
  endtask
  // Bounded wait; running out ends the run
  task automatic await(ref logic s, input int lim, output int n);
    for (n = 0; n < lim && s !== 1'h1; n++)
      @(negedge i_clk);
    if (s !== 1'h1) begin
      check(1'h0, "wait limit");
      give_verdict();
    end
  endtask
  task automatic set_pin(input int p, input logic v);
    if (p == 0)
      i_int_pin = v;
    else
      i_photodiode_sync_pin = v;
  endtask
  ////////////////////////////////////////
  task automatic t_reset_values();
    rd(8'h10, 16'h0000);
    rd(8'h12, 16'h0020);
    rd(8'h31, 16'h0100);
    rd(8'h20, 16'h0000);
  endtask
  // 65 full-scale pulses clip slot A; 128 samples fill 27 bits
  task automatic t_average();
    int n;
    wr(8'h10, 16'h0001);
    wr(8'h12, 16'h0001);
    wr(8'h31, 16'h4100);
    wr(8'h36, 16'h0200);
    wr(8'h15, 16'h0070);
    rd(8'h15, 16'h0070);
    wr(8'h10, 16'h0002);
    // About ten samples in, slot A must not have updated yet
    repeat (2000) @(negedge i_clk);
    check(o_slota_data === 32'h00000000, "early slot A update");
    await(o_fifo_wr, 60000, n);
    check(o_fifo_data === 32'h000FFFFF, "fifo word");
    check(o_slota_data === 32'h07FFFF80, "slot A sum");
    check(o_slotb_data === 32'h00007FFE, "slot B sum");
  endtask
  // Standby keeps data and settings and stays quiet
  task automatic t_standby();
    wr(8'h10, 16'h0001);
    wr(8'h10, 16'h0000);
    repeat (40) @(negedge i_clk);
    check(o_slota_data === 32'h07FFFF80, "data kept");
    rd(8'h31, 16'h4100);
    rd(8'h10, 16'h0000);
  endtask
  // Each trigger pin in turn: ignored in program mode, one start per edge
  task automatic t_ext_trigger();
    int n;
    int busy;
    lag = 4'h5;
    for (int p = 0; p < 2; p++) begin
      wr(8'h10, 16'h0001);
      wr(8'h4F, p == 0 ? 16'h0006 : 16'h0028);
      wr(8'h38, 16'h4000);
      wr(8'h31, 16'h0100);
      wr(8'h15, 16'h0000);
      set_pin(p, 1'h1);
      repeat (4 * SLOW_DIV) @(negedge i_clk);
      set_pin(p, 1'h0);
      wr(8'h10, 16'h0002);
      repeat (6 * SLOW_DIV) @(negedge i_clk);
      check(o_sampling === 1'h0, "start without edge");
      set_pin(p, 1'h1);
      await(o_sampling, 4 * SLOW_DIV, n);
      check(n >= SLOW_DIV && n <= 2 * SLOW_DIV + 6, "trigger delay");
      repeat (4 * SLOW_DIV) @(negedge i_clk);
      busy = 0;
      repeat (8 * SLOW_DIV) begin
        @(negedge i_clk);
        busy += int'(o_sampling === 1'h1);
      end
      check(busy == 0, "second start on held level");
      set_pin(p, 1'h0);
    end
    wr(8'h10, 16'h0001);
  endtask
  // Stopped external slow clock means no samples; running it starts them
  task automatic t_ext_clock();
    logic seen;
    lag = 4'h1;
    seen = 1'h0;
    wr(8'h10, 16'h0000);
    wr(8'h4F, 16'h0020);
    wr(8'h4B, 16'h0180);
    wr(8'h10, 16'h0001);
    wr(8'h38, 16'h0000);
    wr(8'h10, 16'h0002);
    rd(8'h4B, 16'h0180);
    repeat (20 * SLOW_DIV) @(negedge i_clk);
    check(o_sampling === 1'h0, "sample on stopped clock");
    for (int n = 1; n <= 80; n++) begin
      @(negedge i_clk);
      if (n % 10 == 0)
        i_photodiode_sync_pin = ~i_photodiode_sync_pin;
      seen = seen | o_sampling;
    end
    check(seen === 1'h1, "no sample on external clock");
    wr(8'h10, 16'h0001);
  endtask
  initial begin
    repeat (8) @(negedge i_clk);
    i_srst = 1'h0;
    t_reset_values();
    t_average();
    t_standby();
    t_ext_trigger();
    t_ext_clock();
    give_verdict();
  end
endmodule // osq_sequencer_test

bind osq_sequencer osq_sequencer_props u_props (.i_clk, .i_srst, .i_reg_wr, .i_reg_addr, .i_reg_wdata, .o_pulse_req,
  .o_slot_b, .o_power_hold, .o_sampling, .o_data_new, .o_fifo_wr);
